// ### core/rail_cfg_pkg.sv
package rail_cfg_pkg;

   // --------------------------------------------------------------
   // Command codes of the register bank
   // --------------------------------------------------------------
   localparam logic [7:0] CMD_CLAMP_TIME  = 8'hDD;
   localparam logic [7:0] CMD_TRIM_LOW    = 8'hDE;
   localparam logic [7:0] CMD_TRIM_MID    = 8'hDF;
   localparam logic [7:0] CMD_TRIM_HIGH   = 8'hE0;
   localparam logic [7:0] CMD_ADDR_SOURCE = 8'hE1;
   localparam logic [7:0] CMD_LOOP_GAIN   = 8'hE2;
   localparam logic [7:0] CMD_HOLD_CTRL   = 8'hE3;
   localparam logic [7:0] CMD_RAIL_CFG    = 8'hE4;

   // --------------------------------------------------------------
   // Writable bit masks, reserved bits are zero
   // --------------------------------------------------------------
   localparam logic [15:0] MASK_CLAMP  = 16'h03FF;
   localparam logic [15:0] MASK_TRIM15 = 16'h7FFF;
   localparam logic [15:0] MASK_TRIM10 = 16'h03FF;
   localparam logic [15:0] MASK_ADDR   = 16'h01FF;
   localparam logic [15:0] MASK_LOOP   = 16'h07FF;
   localparam logic [15:0] MASK_HOLD   = 16'h00FF;
   localparam logic [15:0] MASK_CFG    = 16'hFFFF;

   // --------------------------------------------------------------
   // Values after reset
   // --------------------------------------------------------------
   localparam logic [15:0] RST_REG   = 16'h0000;
   localparam logic [2:0]  RST_PHASE = 3'h1;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int TRIM_W        = 5;
   localparam int TRIM_F0       = 0;
   localparam int TRIM_F1       = 5;
   localparam int TRIM_F2       = 10;
   localparam int ADDR_UP_SRC   = 8;
   localparam int ADDR_LO_SRC   = 7;
   localparam int ADDR_UP_LSB   = 4;
   localparam int LOOP_READBACK = 10;
   localparam int LOOP_CAL_LSB  = 4;
   localparam int HOLD_TRANS    = 7;
   localparam int HOLD_PERIOD   = 6;
   localparam int HOLD_PHASE    = 5;
   localparam int HOLD_VID      = 4;
   localparam int CFG_CAL_LL    = 15;
   localparam int CFG_CAL_EN    = 14;
   localparam int CFG_FORCE     = 13;
   localparam int CFG_STATE_LSB = 11;
   localparam int CFG_OVERCLK   = 10;
   localparam int CFG_LL_TON    = 9;
   localparam int CFG_STEP      = 8;

   // --------------------------------------------------------------
   // Phase codes and operation encoding
   // --------------------------------------------------------------
   localparam logic [2:0] PH_LIGHT_LOAD = 3'h0;
   localparam logic [2:0] PH_SINGLE     = 3'h1;
   localparam logic [1:0] OP_NO_FORCE   = 2'h3;

   // --------------------------------------------------------------
   // Timing and scaling
   // --------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int HOLD_STEP_NS     = 100000;
   localparam int HOLD_STEP_CYCLES = (HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reference is carried in 10 uV units, one trim step is 2.35 mV
   localparam logic [17:0] TRIM_STEP_10UV = 18'h000EB;

endpackage

// ### core/strap_sync.sv
`timescale 1ns/1ns
`default_nettype none
module strap_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // Pin in, filtered level out
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] level_q;

   // A change counts only once the last two stages agree
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         level_q <= '0;
      end
      else if (ce)
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            level_q <= s3_q;
      end

   assign level = level_q;

endmodule
`default_nettype wire

// ### core/balance_hold_timer.sv
`timescale 1ns/1ns
`default_nettype none
module balance_hold_timer #(
   parameter int STEP_CYCLES = 10000
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Event and length
   input  wire logic       trigger,
   input  wire logic [3:0] steps,
   output logic            busy
);

   logic [15:0] cyc_q;
   logic [3:0]  steps_q;

   // A new event restarts the full hold time
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         cyc_q   <= 16'h0000;
         steps_q <= 4'h0;
      end
      else if (ce)
      begin
         if (trigger)
         begin
            steps_q <= steps;
            cyc_q   <= 16'h0000;
         end
         else if (steps_q != 4'h0)
         begin
            if (cyc_q == 16'(STEP_CYCLES - 1))
            begin
               cyc_q   <= 16'h0000;
               steps_q <= steps_q - 4'h1;
            end
            else
               cyc_q <= cyc_q + 16'h0001;
         end
      end

   assign busy = trigger | (steps_q != 4'h0);

   a_step_count_end : assert property (@(posedge clk) disable iff (rst)
      (ce && !trigger && steps_q != 4'h0 && cyc_q == 16'(STEP_CYCLES - 1))
      |=> (steps_q == $past(steps_q) - 4'h1))
      else $error("hold step did not decrement at end of step");

endmodule
`default_nettype wire

// ### core/rail_trim_address_loop_config.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Reserved bits ignore writes and always read back as zero.
// - Light-load clamp register holds a 10-bit count, 5 ns per step.
// - Low trim register holds two-phase, single-phase and light-load 5-bit trims.
// - Selected trim is subtracted from the regulation reference.
// - Mid trim register holds five, four and three phase trims.
// - High trim register holds seven and six phase trims.
// - Upper address bits come from high strap or register per bit 8.
// - Lower address bits come from low strap or register per bit 7.
// - Address fields read back the bits in use, strap-derived when strapped.
// - Loop register bit 10 selects VID or 1 mV readback format.
// - Loop register carries calibration gain and balance gain.
// - Bit 7 holds balancing when feedback leaves its transient window.
// - Bit 6 holds balancing when the PWM period condition is met.
// - Bit 5 holds on phase count change, bit 4 on voltage transition.
// - Hold lasts the programmed steps of 100 us after an event.
// - Bit 14 enables calibration, bit 15 additionally in light load.
// - Bit 13 forces power state unless operation bits are both one.
// - Forced state 00 full phase count, 01 single, 1x light load.
// - Bit 10 picks bus offset over interface offset, else the reverse.
// - Bit 9 makes light-load on-time three quarters of continuous.
// - Bit 8 picks a 5 mV VID step, else 10 mV.
// - Bits 2 to 0 encode the full phase count.
module rail_trim_address_loop_config #(
   parameter int HOLD_STEP_CYCLES = rail_cfg_pkg::HOLD_STEP_CYCLES
) (
   // Clock, reset, enable
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic        CE,
   // Register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   output logic             REG_RVALID,
   // Address straps and resulting bus address
   input  wire logic [2:0]  ADDR_HIGH_STRAP,
   input  wire logic [3:0]  ADDR_LOW_STRAP,
   output logic      [6:0]  BUS_ADDR,
   // Power state
   input  wire logic [1:0]  OPERATION_MODE,
   input  wire logic [2:0]  PHASE_REQUEST,
   output logic      [2:0]  ACTIVE_PHASE_CODE,
   // Reference trim
   input  wire logic [17:0] REF_IN,
   output logic      [4:0]  APPLIED_TRIM,
   output logic      [17:0] REF_OUT,
   // Balance hold events
   input  wire logic        FB_OUT_OF_WINDOW,
   input  wire logic        PWM_PERIOD_MET,
   input  wire logic        VID_TRANSITION,
   output logic             BALANCE_HOLD,
   // Loop settings
   output logic      [5:0]  CAL_GAIN,
   output logic      [3:0]  BALANCE_GAIN,
   output logic             OFFSET_CAL_ACTIVE,
   output logic             READBACK_MV,
   // Rail options
   input  wire logic [15:0] BUS_OFFSET,
   input  wire logic [15:0] IFACE_OFFSET,
   output logic      [15:0] VID_OFFSET,
   input  wire logic [11:0] CCM_ON_TIME,
   output logic      [11:0] LL_ON_TIME,
   output logic             FINE_VID_STEP,
   output logic      [9:0]  CLAMP_TIME_COUNT
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [15:0] clamp_q;
   logic [15:0] trim_low_q;
   logic [15:0] trim_mid_q;
   logic [15:0] trim_high_q;
   logic [15:0] addr_q;
   logic [15:0] loop_q;
   logic [15:0] hold_q;
   logic [15:0] cfg_q;
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;
   logic        rvalid_q;
   logic [7:0]  rd_addr_q;
   logic [2:0]  high_strap;
   logic [3:0]  low_strap;
   logic [6:0]  addr_d;
   logic [6:0]  addr_out_q;
   logic [2:0]  phase_d;
   logic [2:0]  phase_q;
   logic [2:0]  phase_prev_q;
   logic [4:0]  trim_d;
   logic [4:0]  trim_q;
   logic [17:0] adj;
   logic [17:0] ref_q;
   logic        phase_change;
   logic        hold_trigger;
   logic        hold_busy;
   logic [15:0] offset_q;
   logic [13:0] ton_x3;
   logic [11:0] ton_q;
   logic        cal_q;

   wire logic wr = CE & REG_WR;

   // Writes keep only the defined bits
   always_ff @(posedge CLK_SYS or posedge SYS_RST)
      if (SYS_RST)
      begin
         clamp_q     <= rail_cfg_pkg::RST_REG;
         trim_low_q  <= rail_cfg_pkg::RST_REG;
         trim_mid_q  <= rail_cfg_pkg::RST_REG;
         trim_high_q <= rail_cfg_pkg::RST_REG;
         addr_q      <= rail_cfg_pkg::RST_REG;
         loop_q      <= rail_cfg_pkg::RST_REG;
         hold_q      <= rail_cfg_pkg::RST_REG;
         cfg_q       <= {13'h0000, rail_cfg_pkg::RST_PHASE};
      end
      else if (wr)
      begin
         case (REG_ADDR)
            rail_cfg_pkg::CMD_CLAMP_TIME  : clamp_q     <= REG_WDATA & rail_cfg_pkg::MASK_CLAMP;
            rail_cfg_pkg::CMD_TRIM_LOW    : trim_low_q  <= REG_WDATA & rail_cfg_pkg::MASK_TRIM15;
            rail_cfg_pkg::CMD_TRIM_MID    : trim_mid_q  <= REG_WDATA & rail_cfg_pkg::MASK_TRIM15;
            rail_cfg_pkg::CMD_TRIM_HIGH   : trim_high_q <= REG_WDATA & rail_cfg_pkg::MASK_TRIM10;
            rail_cfg_pkg::CMD_ADDR_SOURCE : addr_q      <= REG_WDATA & rail_cfg_pkg::MASK_ADDR;
            rail_cfg_pkg::CMD_LOOP_GAIN   : loop_q      <= REG_WDATA & rail_cfg_pkg::MASK_LOOP;
            rail_cfg_pkg::CMD_HOLD_CTRL   : hold_q      <= REG_WDATA & rail_cfg_pkg::MASK_HOLD;
            rail_cfg_pkg::CMD_RAIL_CFG    : cfg_q       <= REG_WDATA & rail_cfg_pkg::MASK_CFG;
            default                       : ;
         endcase
      end

   // ----------------------------------------------------------------
   // Bus address from straps or register
   // ----------------------------------------------------------------
   strap_sync #(.WIDTH(3)) u_high_sync (
      .clk   (CLK_SYS),
      .rst   (SYS_RST),
      .ce    (CE),
      .pin   (ADDR_HIGH_STRAP),
      .level (high_strap)
   );

   strap_sync #(.WIDTH(4)) u_low_sync (
      .clk   (CLK_SYS),
      .rst   (SYS_RST),
      .ce    (CE),
      .pin   (ADDR_LOW_STRAP),
      .level (low_strap)
   );

   always_comb
   begin
      addr_d[6:4] = addr_q[rail_cfg_pkg::ADDR_UP_SRC] ? addr_q[6:4] : high_strap;
      addr_d[3:0] = addr_q[rail_cfg_pkg::ADDR_LO_SRC] ? addr_q[3:0] : low_strap;
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST)
      if (SYS_RST)
         addr_out_q <= 7'h00;
      else if (CE)
         addr_out_q <= addr_d;

   // ----------------------------------------------------------------
   // Read path, one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb
   begin
      case (REG_ADDR)
         rail_cfg_pkg::CMD_CLAMP_TIME  : rdata_d = clamp_q;
         rail_cfg_pkg::CMD_TRIM_LOW    : rdata_d = trim_low_q;
         rail_cfg_pkg::CMD_TRIM_MID    : rdata_d = trim_mid_q;
         rail_cfg_pkg::CMD_TRIM_HIGH   : rdata_d = trim_high_q;
         rail_cfg_pkg::CMD_ADDR_SOURCE : rdata_d = {addr_q[15:7], addr_d};
         rail_cfg_pkg::CMD_LOOP_GAIN   : rdata_d = loop_q;
         rail_cfg_pkg::CMD_HOLD_CTRL   : rdata_d = hold_q;
         rail_cfg_pkg::CMD_RAIL_CFG    : rdata_d = cfg_q;
         default                       : rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST)
      if (SYS_RST)
      begin
         rdata_q   <= 16'h0000;
         rvalid_q  <= 1'b0;
         rd_addr_q <= 8'h00;
      end
      else if (CE)
      begin
         rvalid_q <= REG_RD;
         if (REG_RD)
         begin
            rdata_q   <= rdata_d;
            rd_addr_q <= REG_ADDR;
         end
      end

   // ----------------------------------------------------------------
   // Active power state and trim selection
   // ----------------------------------------------------------------
   always_comb
   begin
      phase_d = PHASE_REQUEST;
      // Forcing is blocked while the operation command claims the state
      if (cfg_q[rail_cfg_pkg::CFG_FORCE] && OPERATION_MODE != rail_cfg_pkg::OP_NO_FORCE)
      begin
         case (cfg_q[12:11])
            2'h0    : phase_d = cfg_q[2:0];
            2'h1    : phase_d = rail_cfg_pkg::PH_SINGLE;
            default : phase_d = rail_cfg_pkg::PH_LIGHT_LOAD;
         endcase
      end
   end

   always_comb
   begin
      case (phase_q)
         3'h0    : trim_d = trim_low_q[rail_cfg_pkg::TRIM_F0 +: rail_cfg_pkg::TRIM_W];
         3'h1    : trim_d = trim_low_q[rail_cfg_pkg::TRIM_F1 +: rail_cfg_pkg::TRIM_W];
         3'h2    : trim_d = trim_low_q[rail_cfg_pkg::TRIM_F2 +: rail_cfg_pkg::TRIM_W];
         3'h3    : trim_d = trim_mid_q[rail_cfg_pkg::TRIM_F0 +: rail_cfg_pkg::TRIM_W];
         3'h4    : trim_d = trim_mid_q[rail_cfg_pkg::TRIM_F1 +: rail_cfg_pkg::TRIM_W];
         3'h5    : trim_d = trim_mid_q[rail_cfg_pkg::TRIM_F2 +: rail_cfg_pkg::TRIM_W];
         3'h6    : trim_d = trim_high_q[rail_cfg_pkg::TRIM_F0 +: rail_cfg_pkg::TRIM_W];
         default : trim_d = trim_high_q[rail_cfg_pkg::TRIM_F1 +: rail_cfg_pkg::TRIM_W];
      endcase
   end

   // Trim lags the state by one cycle, reference by two
   assign adj = {13'h0000, trim_q} * rail_cfg_pkg::TRIM_STEP_10UV;

   always_ff @(posedge CLK_SYS or posedge SYS_RST)
      if (SYS_RST)
      begin
         phase_q      <= rail_cfg_pkg::RST_PHASE;
         phase_prev_q <= rail_cfg_pkg::RST_PHASE;
         trim_q       <= 5'h00;
         ref_q        <= 18'h00000;
      end
      else if (CE)
      begin
         phase_q      <= phase_d;
         phase_prev_q <= phase_q;
         trim_q       <= trim_d;
         // Clamp at zero rather than wrap on a large trim
         ref_q        <= (REF_IN > adj) ? REF_IN - adj : 18'h00000;
      end

   // ----------------------------------------------------------------
   // Balance hold
   // ----------------------------------------------------------------
   assign phase_change = (phase_q != phase_prev_q);
   assign hold_trigger = (hold_q[rail_cfg_pkg::HOLD_TRANS]  & FB_OUT_OF_WINDOW)
                       | (hold_q[rail_cfg_pkg::HOLD_PERIOD] & PWM_PERIOD_MET)
                       | (hold_q[rail_cfg_pkg::HOLD_PHASE]  & phase_change)
                       | (hold_q[rail_cfg_pkg::HOLD_VID]    & VID_TRANSITION);

   balance_hold_timer #(.STEP_CYCLES(HOLD_STEP_CYCLES)) u_hold (
      .clk     (CLK_SYS),
      .rst     (SYS_RST),
      .ce      (CE),
      .trigger (hold_trigger),
      .steps   (hold_q[3:0]),
      .busy    (hold_busy)
   );

   // ----------------------------------------------------------------
   // Rail options
   // ----------------------------------------------------------------
   assign ton_x3 = {2'h0, CCM_ON_TIME} + {1'h0, CCM_ON_TIME, 1'h0};

   always_ff @(posedge CLK_SYS or posedge SYS_RST)
      if (SYS_RST)
      begin
         offset_q <= 16'h0000;
         ton_q    <= 12'h000;
         cal_q    <= 1'b0;
      end
      else if (CE)
      begin
         offset_q <= cfg_q[rail_cfg_pkg::CFG_OVERCLK] ? BUS_OFFSET : IFACE_OFFSET;
         ton_q    <= cfg_q[rail_cfg_pkg::CFG_LL_TON] ? ton_x3[13:2] : CCM_ON_TIME;
         cal_q    <= cfg_q[rail_cfg_pkg::CFG_CAL_EN]
                     & ((phase_q != rail_cfg_pkg::PH_LIGHT_LOAD)
                        | cfg_q[rail_cfg_pkg::CFG_CAL_LL]);
      end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_RDATA         = rdata_q;
   assign REG_RVALID        = rvalid_q;
   assign BUS_ADDR          = addr_out_q;
   assign ACTIVE_PHASE_CODE = phase_q;
   assign APPLIED_TRIM      = trim_q;
   assign REF_OUT           = ref_q;
   assign BALANCE_HOLD      = hold_busy;
   assign CAL_GAIN          = loop_q[9:4];
   assign BALANCE_GAIN      = loop_q[3:0];
   assign READBACK_MV       = loop_q[rail_cfg_pkg::LOOP_READBACK];
   assign OFFSET_CAL_ACTIVE = cal_q;
   assign VID_OFFSET        = offset_q;
   assign LL_ON_TIME        = ton_q;
   assign FINE_VID_STEP     = cfg_q[rail_cfg_pkg::CFG_STEP];
   assign CLAMP_TIME_COUNT  = clamp_q[9:0];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_reserved_reads_zero : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (REG_RVALID && rd_addr_q == rail_cfg_pkg::CMD_LOOP_GAIN) |-> (REG_RDATA[15:11] == 5'h00))
      else $error("reserved loop bits read nonzero");

   a_upper_addr_src : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && !addr_q[rail_cfg_pkg::ADDR_UP_SRC]) |=> (BUS_ADDR[6:4] == $past(high_strap)))
      else $error("upper address not taken from strap");

   a_lower_addr_src : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && addr_q[rail_cfg_pkg::ADDR_LO_SRC]) |=> (BUS_ADDR[3:0] == $past(addr_q[3:0])))
      else $error("lower address not taken from register");

   a_addr_readback : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && REG_RD && REG_ADDR == rail_cfg_pkg::CMD_ADDR_SOURCE)
      |=> (REG_RVALID && REG_RDATA[6:0] == $past(addr_d)))
      else $error("address readback differs from address in use");

   a_force_blocked : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && OPERATION_MODE == rail_cfg_pkg::OP_NO_FORCE) |=> (phase_q == $past(PHASE_REQUEST)))
      else $error("power state forced while operation claims it");

   a_force_light_load : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && cfg_q[rail_cfg_pkg::CFG_FORCE] && cfg_q[12] && OPERATION_MODE != rail_cfg_pkg::OP_NO_FORCE)
      |=> (phase_q == rail_cfg_pkg::PH_LIGHT_LOAD))
      else $error("forced light load not applied");

   a_trim_follows : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && phase_q == 3'h2 && !wr) |=> (APPLIED_TRIM == $past(trim_low_q[14:10])))
      else $error("two phase trim not applied");

   a_ref_subtract : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && REF_IN > adj) |=> (REF_OUT == $past(REF_IN) - $past(adj)))
      else $error("reference not reduced by trim");

   a_hold_on_window : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (hold_q[rail_cfg_pkg::HOLD_TRANS] && FB_OUT_OF_WINDOW) |-> BALANCE_HOLD)
      else $error("no hold on transient window exit");

   a_no_hold_disabled : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && !wr && hold_q[7:4] == 4'h0 && !hold_busy) |=> !BALANCE_HOLD)
      else $error("hold with every event disabled");

   a_on_time_scale : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (CE && cfg_q[rail_cfg_pkg::CFG_LL_TON]) |=> (LL_ON_TIME == $past(ton_x3[13:2])))
      else $error("light load on-time not three quarters");

endmodule
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // Clock and answer
   input  wire logic        clk,
   input  wire logic [15:0] rdata,
   input  wire logic        rvalid,
   // Request
   output logic      [7:0]  addr,
   output logic             wr,
   output logic             rd,
   output logic      [15:0] wdata
);
   // ---------------------------
   // Bus cycles
   // ---------------------------
   initial
   begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 16'h0000;
   end
   task automatic write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // Idle data shows the inverse, so a stale word never matches
      wdata <= ~d;
   endtask
   // Answer is sampled 1 ns after the take edge
   task automatic read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = (rvalid === 1'b1) ? rdata : ~rdata;
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk_sys = 1'b0, sys_rst = 1'b1;
   logic        wr, rd, rvalid, hold, cal_act, rb_mv, fine;
   logic        fb = 1'b0, pwm = 1'b0, vidt = 1'b0;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, v, vid_off;
   logic [1:0]  op_mode = 2'h0;
   logic        ce = 1'b1;
   logic [15:0] iface = 16'h0ABC;
   logic [17:0] ref_in = 18'h10000;
   logic [2:0]  ph_req = 3'h0, act_ph;
   logic [6:0]  bus_addr;
   logic [4:0]  trim;
   logic [17:0] ref_out;
   logic [5:0]  cal_gain;
   logic [3:0]  bal_gain;
   logic [11:0] ll_t;
   logic [9:0]  clamp;
   int          err_total = 0, checks = 0, cyc = 0;
   initial forever #5 clk_sys = ~clk_sys;
   host_model u_host (.clk(clk_sys), .rdata(rdata), .rvalid(rvalid), .addr(addr),
      .wr(wr), .rd(rd), .wdata(wdata));
   // Short hold steps keep the run brief
   rail_trim_address_loop_config #(.HOLD_STEP_CYCLES(4)) u_dut (
      .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(ce), .REG_ADDR(addr), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .ADDR_HIGH_STRAP(3'h5), .ADDR_LOW_STRAP(4'hA), .BUS_ADDR(bus_addr),
      .OPERATION_MODE(op_mode), .PHASE_REQUEST(ph_req), .ACTIVE_PHASE_CODE(act_ph),
      .REF_IN(ref_in), .APPLIED_TRIM(trim), .REF_OUT(ref_out),
      .FB_OUT_OF_WINDOW(fb), .PWM_PERIOD_MET(pwm), .VID_TRANSITION(vidt),
      .BALANCE_HOLD(hold), .CAL_GAIN(cal_gain), .BALANCE_GAIN(bal_gain),
      .OFFSET_CAL_ACTIVE(cal_act), .READBACK_MV(rb_mv), .BUS_OFFSET(16'h1234),
      .IFACE_OFFSET(iface), .VID_OFFSET(vid_off), .CCM_ON_TIME(12'h065),
      .LL_ON_TIME(ll_t), .FINE_VID_STEP(fine), .CLAMP_TIME_COUNT(clamp));
   task automatic chk(input logic [17:0] g, input logic [17:0] e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      u_host.read(a, v);
      chk({2'h0, v}, {2'h0, e});
   endtask
   task automatic t_regs;
      logic [7:0]  a [8] = '{8'hDD, 8'hDE, 8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4};
      logic [15:0] m [8] = '{16'h03FF, 16'h7FFF, 16'h7FFF, 16'h03FF, 16'h01FF,
                             16'h07FF, 16'h00FF, 16'hFFFF};
      rchk(8'hE4, 16'h0001);
      for (int i = 0; i < 8; i++)
      begin
         u_host.write(a[i], 16'hFFFF);
         rchk(a[i], m[i]);
      end
      rchk(8'h10, 16'h0000);
      chk(18'(clamp), 18'h003FF);
      chk(18'({rb_mv, cal_gain, bal_gain}), 18'h007FF);
   endtask
   task automatic t_addr;
      u_host.write(8'hE1, 16'h007F);
      rchk(8'hE1, 16'h005A);
      chk(18'(bus_addr), 18'h0005A);
      u_host.write(8'hE1, 16'h0123);
      rchk(8'hE1, 16'h012A);
      chk(18'(bus_addr), 18'h0002A);
      u_host.write(8'hE1, 16'h00A3);
      rchk(8'hE1, 16'h00D3);
      chk(18'(bus_addr), 18'h00053);
   endtask
   // Trim of code c is c + 1 by the table written below
   task automatic ph(input logic [15:0] cfg, input logic [1:0] op,
                     input logic [2:0] req, input logic [2:0] e);
      u_host.write(8'hE4, cfg);
      @(posedge clk_sys);
      op_mode <= op;
      ph_req <= req;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(18'(act_ph), 18'(e));
      chk(18'(trim), 18'(e) + 18'h00001);
      chk(ref_out, 18'h10000 - (18'(e) + 18'h00001) * 18'h000EB);
   endtask
   task automatic t_trim;
      u_host.write(8'hDE, 16'h0C41);
      u_host.write(8'hDF, 16'h18A4);
      u_host.write(8'hE0, 16'h0107);
      for (int c = 0; c < 8; c++)
         ph(16'h0000, 2'h0, 3'(c), 3'(c));
      ph(16'h2805, 2'h0, 3'h7, 3'h1);
      ph(16'h2805, 2'h3, 3'h7, 3'h7);
      ph(16'h3005, 2'h0, 3'h7, 3'h0);
      ph(16'h2005, 2'h0, 3'h7, 3'h5);
      ph(16'h0000, 2'h0, 3'h0, 3'h0);
      // A reference below the trim clamps at zero instead of wrapping
      @(posedge clk_sys);
      ref_in <= 18'h00050;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(ref_out, 18'h00000);
   endtask
   task automatic ev(input logic [7:0] cfg, input logic [2:0] evt, input logic [2:0] req,
                     input logic e);
      u_host.write(8'hE3, {8'h00, cfg});
      @(posedge clk_sys);
      {fb, pwm, vidt} <= evt;
      ph_req <= req;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(18'(hold), 18'(e));
      @(posedge clk_sys);
      {fb, pwm, vidt} <= 3'h0;
      repeat (20) @(posedge clk_sys);
   endtask
   task automatic t_hold;
      ev(8'h81, 3'h4, 3'h0, 1'b1);
      ev(8'h41, 3'h4, 3'h0, 1'b0);
      ev(8'h41, 3'h2, 3'h0, 1'b1);
      ev(8'h11, 3'h1, 3'h0, 1'b1);
      ev(8'h21, 3'h0, 3'h3, 1'b1);
      ev(8'h01, 3'h7, 3'h0, 1'b0);
      u_host.write(8'hE3, 16'h0082);
      @(posedge clk_sys);
      fb <= 1'b1;
      @(posedge clk_sys);
      fb <= 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      chk(18'(hold), 18'h00001);
      repeat (6) @(posedge clk_sys);
      #1;
      chk(18'(hold), 18'h00000);
   endtask
   task automatic t_rail(input logic [15:0] cfg, input logic [15:0] off, input logic [3:0] o);
      u_host.write(8'hE4, cfg);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(18'(vid_off), 18'(off));
      chk(18'(ll_t), o[1] ? 18'h0004B : 18'h00065);
      chk(18'({fine, cal_act}), 18'({o[2], o[0]}));
   endtask
   // A write made while the enable is low must not land
   task automatic t_freeze;
      u_host.write(8'hE2, 16'h0453);
      @(posedge clk_sys);
      ce <= 1'b0;
      chk(18'({rb_mv, cal_gain, bal_gain}), 18'h00453);
      u_host.write(8'hE2, 16'h0000);
      ce <= 1'b1;
      rchk(8'hE2, 16'h0453);
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         err_total++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs();
      t_addr();
      t_trim();
      t_hold();
      t_rail(16'h4700, 16'h1234, 4'h6);
      t_rail(16'hC000, 16'h0ABC, 4'h1);
      t_freeze();
      end_of_test();
   end
endmodule
`default_nettype wire
